// [pkg/uitc_pkg.sv]
// Constants and types shared by the UART interrupt and transmit control.
// Assumes one clock domain and a host front end that decodes transactions.
package uitc_pkg;
    // Transaction kinds presented with a chip-select rising edge
    localparam logic [1:0]  TXN_RD_DATA  = 2'h0;
    localparam logic [1:0]  TXN_RD_CFG   = 2'h1;
    localparam logic [1:0]  TXN_WR_DATA  = 2'h2;
    localparam logic [1:0]  TXN_WR_CFG   = 2'h3;
    // Oversampling counts per bit period
    localparam logic [3:0]  OS_LAST      = 4'hF;
    localparam logic [3:0]  OS_HALF      = 4'h7;
    // Receive buffer
    localparam int          FIFO_DEPTH   = 8;
    localparam logic [3:0]  FIFO_FULL    = 4'h8;
    localparam logic [2:0]  PTR_STEP     = 3'h1;
    // Frame shaping: start, eight data bits and one stop bit
    localparam logic [3:0]  FRAME_BASE   = 4'hA;
    localparam logic [3:0]  RX_LAST_7    = 4'h7;
    localparam logic [3:0]  RX_LAST_8    = 4'h8;
    // Values after reset
    localparam logic [11:0] SHIFT_IDLE   = 12'hFFF;
    localparam logic        LINE_IDLE    = 1'h1;
    localparam logic        EMPTY_RST    = 1'h1;
    localparam logic [1:0]  RST_SYNC_RST = 2'h0;

    typedef enum logic [1:0] {
        TX_IDLE  = 2'b01,
        TX_SHIFT = 2'b10
    } uitc_tx_state_t;

    typedef enum logic [3:0] {
        RX_IDLE  = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA  = 4'b0100,
        RX_STOP  = 4'b1000
    } uitc_rx_state_t;
endpackage

// [core/uitc_rx.sv]
// Character receiver, sixteen oversampling ticks per bit.
// Assumes rx_i is already synchronised and os_tick_i is a one-cycle pulse.
`timescale 1ns/10ps
module uitc_rx (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // Control
    input  wire logic       enable_i,
    input  wire logic       ninth_bit_enable_i,
    input  wire logic       os_tick_i,
    input  wire logic       rx_i,
    // Character out
    output logic            char_valid_o,
    output logic [7:0]      char_byte_o,
    output logic            char_ninth_o,
    output logic            frame_err_o
);
    typedef struct packed {
        uitc_pkg::uitc_rx_state_t state;
        logic [3:0]               os_cnt;
        logic [3:0]               bit_idx;
        logic [8:0]               shift;
        logic                     valid;
        logic                     ferr;
        logic [7:0]               data;
        logic                     ninth;
        logic                     prev;
    } uitc_rx_q_t;

    uitc_rx_q_t q;
    uitc_rx_q_t n;
    logic [3:0] last_idx;

    always_comb
    begin
        n = q;
        n.valid = 1'b0;
        n.ferr = 1'b0;
        n.prev = rx_i;
        last_idx = ninth_bit_enable_i ? uitc_pkg::RX_LAST_8 : uitc_pkg::RX_LAST_7;
        case (q.state)
            uitc_pkg::RX_IDLE:
            begin
                n.os_cnt = 4'h0;
                // Start only on a falling edge, not a held-low line [RQ18]
                if (q.prev && !rx_i)
                    n.state = uitc_pkg::RX_START;
            end
            uitc_pkg::RX_START:
            begin
                if (os_tick_i)
                begin
                    n.os_cnt = q.os_cnt + 4'h1;
                    if (q.os_cnt == uitc_pkg::OS_HALF)
                    begin
                        n.os_cnt = 4'h0;
                        n.bit_idx = 4'h0;
                        n.state = rx_i ? uitc_pkg::RX_IDLE : uitc_pkg::RX_DATA;
                    end
                end
            end
            uitc_pkg::RX_DATA:
            begin
                if (os_tick_i)
                begin
                    n.os_cnt = q.os_cnt + 4'h1;
                    if (q.os_cnt == uitc_pkg::OS_LAST)
                    begin
                        n.shift[q.bit_idx] = rx_i;
                        n.bit_idx = q.bit_idx + 4'h1;
                        if (q.bit_idx == last_idx)
                            n.state = uitc_pkg::RX_STOP;
                    end
                end
            end
            uitc_pkg::RX_STOP:
            begin
                if (os_tick_i)
                begin
                    n.os_cnt = q.os_cnt + 4'h1;
                    if (q.os_cnt == uitc_pkg::OS_LAST)
                    begin
                        // Single stop bit accepted [RQ2]
                        n.state = uitc_pkg::RX_IDLE;
                        n.valid = rx_i;
                        // Zero at first stop: flag and hunt again [RQ17] [RQ18]
                        n.ferr = !rx_i;
                        n.data = q.shift[7:0];
                        n.ninth = ninth_bit_enable_i & q.shift[8]; // [RQ10]
                    end
                end
            end
            default: n.state = uitc_pkg::RX_IDLE;
        endcase
        if (!enable_i)
        begin
            n.state = uitc_pkg::RX_IDLE;
            n.valid = 1'b0;
            n.ferr = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            q <= '0;
            q.state <= uitc_pkg::RX_IDLE;
            q.prev <= uitc_pkg::LINE_IDLE;
        end
        else
            q <= n;
    end

    assign char_valid_o = q.valid;
    assign char_byte_o = q.data;
    assign char_ninth_o = q.ninth;
    assign frame_err_o = q.ferr;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_ferr_idle;
        frame_err_o |-> q.state == uitc_pkg::RX_IDLE;
    endproperty
    a_ferr_idle: assert property (p_ferr_idle) else $error("receiver not idle after framing error"); // [RQ18]

    property p_one_stop;
        (enable_i && q.state == uitc_pkg::RX_STOP && os_tick_i && rx_i
            && q.os_cnt == uitc_pkg::OS_LAST) |=> char_valid_o && !frame_err_o;
    endproperty
    a_one_stop: assert property (p_one_stop) else $error("character lost after one stop bit"); // [RQ2]

    property p_hunt_edge;
        (q.state == uitc_pkg::RX_IDLE && !q.prev) |=> q.state == uitc_pkg::RX_IDLE;
    endproperty
    a_hunt_edge: assert property (p_hunt_edge) else $error("start taken without falling edge"); // [RQ18]
endmodule

// [core/uitc_core.sv]
// Interrupt sources, masks, transmit control and receive buffer of a small UART.
// Assumes a host front end on clk_i that decodes each transaction and pulses
// cs_rise_i at its commit; os_tick_i is a sixteen-times-baud pulse on clk_i.
// Behaviour
// RQ1: Stop-count bit selects one or two stops
// RQ2: Receiver accepts a single stop bit
// RQ3: Configuration read returns stop-count and others
// RQ4: Transmit-empty flag shows empty buffer, resets high
// RQ5: Inhibited data write updates only request-to-send
// RQ6: Masked transmit-empty interrupt on becoming empty
// RQ7: Data read clears transmit-empty source, flag stays
// RQ8: Data read releases the pending interrupt
// RQ9: Ninth-bit flag follows oldest buffered word
// RQ10: Ninth-bit flag needs option on and bit one
// RQ11: Data-available interrupt holds while flag and mask
// RQ12: Data-available clears when buffer read empty
// RQ13: Shared flag: activity in shutdown, framing otherwise
// RQ14: Activity sets on line change, clears on exit
// RQ15: Masked shared flag interrupts in both modes
// RQ16: Framing error follows current character, not buffered
// RQ17: Framing sets on bad stop, clears on good
// RQ18: Framing error returns receiver to start hunt
// RQ19: Data read keeps framing flag; config write clears
// RQ20: Interrupt is OR of masked sources, else high
`timescale 1ns/10ps
module uitc_core (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    // Transaction commit
    input  wire logic       cs_rise_i,
    input  wire logic [1:0] txn_kind_i,
    // Write-configuration fields
    input  wire logic       cfg_stop_count_select_i,
    input  wire logic       cfg_ninth_bit_enable_i,
    input  wire logic       cfg_tx_empty_mask_i,
    input  wire logic       cfg_rx_avail_mask_i,
    input  wire logic       cfg_ninth_bit_mask_i,
    input  wire logic       cfg_activity_mask_i,
    input  wire logic       cfg_shutdown_i,
    // Write-data fields
    input  wire logic       wr_tx_inhibit_i,
    input  wire logic       wr_rts_i,
    input  wire logic       wr_tx_ninth_bit_i,
    input  wire logic [7:0] wr_tx_byte_i,
    // Serial side
    input  wire logic       os_tick_i,
    input  wire logic       rx_i,
    output logic            tx_o,
    output logic            rts_n_o,
    // Read-back
    output logic            rd_stop_count_select_o,
    output logic            rd_ninth_bit_enable_o,
    output logic            rd_tx_empty_mask_o,
    output logic            rd_rx_avail_mask_o,
    output logic            rd_ninth_bit_mask_o,
    output logic            rd_activity_mask_o,
    output logic            rd_shutdown_o,
    output logic            rd_tx_empty_o,
    output logic            rd_rx_avail_o,
    output logic            rd_rx_ninth_bit_o,
    output logic            rd_activity_or_framing_flag_o,
    output logic [7:0]      rd_rx_byte_o,
    // Interrupt
    output logic            irq_n_o
);
    typedef struct packed {
        logic                                 rx_meta;
        logic                                 rx_sync;
        logic                                 rx_prev;
        logic                                 stop_count;
        logic                                 ninth_en;
        logic                                 tx_mask;
        logic                                 rx_mask;
        logic                                 ninth_mask;
        logic                                 act_mask;
        logic                                 shdn_req;
        logic                                 in_shdn;
        logic                                 rts;
        logic                                 hold_valid;
        logic [8:0]                           hold_data;
        uitc_pkg::uitc_tx_state_t             tx_state;
        logic [11:0]                          shift;
        logic [3:0]                           bits_left;
        logic [3:0]                           os_cnt;
        logic [uitc_pkg::FIFO_DEPTH-1:0][8:0] mem;
        logic [2:0]                           wr_ptr;
        logic [2:0]                           rd_ptr;
        logic [3:0]                           count;
        logic                                 act_flag;
        logic                                 tx_src;
        logic                                 empty_prev;
    } uitc_core_q_t;

    uitc_core_q_t q;
    uitc_core_q_t n;
    logic [1:0]   rst_sync_r;
    logic         rst_n;
    logic         wr_cfg;
    logic         wr_data;
    logic         rd_data;
    logic         push;
    logic         pop;
    logic         shdn_enter;
    logic         fe_set;
    logic         fe_clr;
    logic         tx_set;
    logic         rx_valid;
    logic [7:0]   rx_byte;
    logic         rx_ninth;
    logic         rx_ferr;

    function automatic logic [2:0] ptr_inc(input logic [2:0] p);
        ptr_inc = p + uitc_pkg::PTR_STEP;
    endfunction

    function automatic logic [11:0] tx_frame(input logic [8:0] d, input logic ne);
        tx_frame = ne ? {2'h3, d, 1'b0} : {3'h7, d[7:0], 1'b0};
    endfunction

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            rst_sync_r <= uitc_pkg::RST_SYNC_RST;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    assign wr_cfg = cs_rise_i && txn_kind_i == uitc_pkg::TXN_WR_CFG;
    assign wr_data = cs_rise_i && txn_kind_i == uitc_pkg::TXN_WR_DATA;
    assign rd_data = cs_rise_i && txn_kind_i == uitc_pkg::TXN_RD_DATA;
    assign push = rx_valid && !q.in_shdn && q.count < uitc_pkg::FIFO_FULL;
    assign pop = rd_data && q.count != 4'h0;
    assign shdn_enter = q.shdn_req && !q.in_shdn && !q.hold_valid
                        && q.tx_state == uitc_pkg::TX_IDLE && !(wr_cfg && !cfg_shutdown_i);
    // Activity in shutdown, framing error otherwise [RQ13]
    assign fe_set = q.in_shdn ? (q.rx_sync != q.rx_prev) : rx_ferr; // [RQ14] [RQ17]
    assign fe_clr = (!q.in_shdn && (rx_valid || wr_cfg)) // [RQ17] [RQ19]
                    || (q.in_shdn && wr_cfg && !cfg_shutdown_i) || shdn_enter; // [RQ14]
    assign tx_set = !q.hold_valid && !q.empty_prev;

    uitc_rx u_rx (
        .clk_i              (clk_i),
        .rst_n_i            (rst_n),
        .enable_i           (!q.in_shdn),
        .ninth_bit_enable_i (q.ninth_en),
        .os_tick_i          (os_tick_i),
        .rx_i               (q.rx_sync),
        .char_valid_o       (rx_valid),
        .char_byte_o        (rx_byte),
        .char_ninth_o       (rx_ninth),
        .frame_err_o        (rx_ferr)
    );

    always_comb
    begin
        n = q;
        n.rx_meta = rx_i;
        n.rx_sync = q.rx_meta;
        n.rx_prev = q.rx_sync;
        if (wr_cfg)
        begin
            n.stop_count = cfg_stop_count_select_i;
            n.ninth_en = cfg_ninth_bit_enable_i;
            n.tx_mask = cfg_tx_empty_mask_i;
            n.rx_mask = cfg_rx_avail_mask_i;
            n.ninth_mask = cfg_ninth_bit_mask_i;
            n.act_mask = cfg_activity_mask_i;
            n.shdn_req = cfg_shutdown_i;
            if (!cfg_shutdown_i)
                n.in_shdn = 1'b0;
        end
        case (q.tx_state)
            uitc_pkg::TX_IDLE:
            begin
                if (q.hold_valid && !q.in_shdn)
                begin
                    n.shift = tx_frame(q.hold_data, q.ninth_en);
                    // Frame length adds the ninth bit and second stop [RQ1]
                    n.bits_left = uitc_pkg::FRAME_BASE + {3'h0, q.ninth_en}
                                  + {3'h0, q.stop_count};
                    n.os_cnt = 4'h0;
                    n.hold_valid = 1'b0;
                    n.tx_state = uitc_pkg::TX_SHIFT;
                end
            end
            uitc_pkg::TX_SHIFT:
            begin
                if (os_tick_i)
                begin
                    n.os_cnt = q.os_cnt + 4'h1;
                    if (q.os_cnt == uitc_pkg::OS_LAST)
                    begin
                        n.shift = {1'b1, q.shift[11:1]};
                        n.bits_left = q.bits_left - 4'h1;
                        if (q.bits_left == 4'h1)
                            n.tx_state = uitc_pkg::TX_IDLE;
                    end
                end
            end
            default: n.tx_state = uitc_pkg::TX_IDLE;
        endcase
        if (wr_data)
        begin
            n.rts = wr_rts_i;
            // Data queued only when not inhibited and buffer free [RQ5]
            if (!wr_tx_inhibit_i && !q.hold_valid && !q.in_shdn)
            begin
                n.hold_valid = 1'b1;
                n.hold_data = {wr_tx_ninth_bit_i, wr_tx_byte_i};
            end
        end
        if (push)
        begin
            n.mem[q.wr_ptr] = {rx_ninth, rx_byte};
            n.wr_ptr = ptr_inc(q.wr_ptr);
        end
        if (pop)
            n.rd_ptr = ptr_inc(q.rd_ptr);
        case ({push, pop})
            2'b10: n.count = q.count + 4'h1;
            2'b01: n.count = q.count - 4'h1; // [RQ12]
            default: n.count = q.count;
        endcase
        if (shdn_enter)
        begin
            n.in_shdn = 1'b1;
            n.wr_ptr = 3'h0;
            n.rd_ptr = 3'h0;
            n.count = 4'h0;
            n.hold_data = 9'h000;
        end
        // Outside shutdown the flag tracks the current character only [RQ16]
        if (fe_set)
            n.act_flag = 1'b1;
        else if (fe_clr)
            n.act_flag = 1'b0;
        n.empty_prev = !q.hold_valid;
        // Source latches on becoming empty, read-data clears [RQ6] [RQ7]
        if (tx_set)
            n.tx_src = 1'b1;
        else if (rd_data)
            n.tx_src = 1'b0; // [RQ8]
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= '0;
            q.rx_meta <= uitc_pkg::LINE_IDLE;
            q.rx_sync <= uitc_pkg::LINE_IDLE;
            q.rx_prev <= uitc_pkg::LINE_IDLE;
            q.tx_state <= uitc_pkg::TX_IDLE;
            q.shift <= uitc_pkg::SHIFT_IDLE;
            q.empty_prev <= uitc_pkg::EMPTY_RST;
        end
        else
            q <= n;
    end

    assign tx_o = q.shift[0];
    assign rts_n_o = !q.rts;
    // Configuration read-back [RQ3]
    assign rd_stop_count_select_o = q.stop_count;
    assign rd_ninth_bit_enable_o = q.ninth_en;
    assign rd_tx_empty_mask_o = q.tx_mask;
    assign rd_rx_avail_mask_o = q.rx_mask;
    assign rd_ninth_bit_mask_o = q.ninth_mask;
    assign rd_activity_mask_o = q.act_mask;
    assign rd_shutdown_o = q.in_shdn;
    assign rd_tx_empty_o = !q.hold_valid; // [RQ4]
    assign rd_rx_avail_o = q.count != 4'h0; // [RQ11]
    // Head of buffer is the word the next data read returns [RQ9]
    assign rd_rx_ninth_bit_o = rd_rx_avail_o && q.mem[q.rd_ptr][8];
    assign rd_rx_byte_o = q.mem[q.rd_ptr][7:0];
    assign rd_activity_or_framing_flag_o = q.act_flag;
    // OR of the four masked sources [RQ20] [RQ15] [RQ11] [RQ6]
    assign irq_n_o = !((rd_rx_ninth_bit_o && q.ninth_mask)
                       || (rd_rx_avail_o && q.rx_mask)
                       || (q.act_flag && q.act_mask)
                       || (q.tx_src && q.tx_mask));

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    sequence s_tx_load;
        q.tx_state == uitc_pkg::TX_IDLE && q.hold_valid && !q.in_shdn;
    endsequence

    property p_stop_len;
        s_tx_load |=> q.bits_left == uitc_pkg::FRAME_BASE
            + {3'h0, $past(q.ninth_en)} + {3'h0, $past(q.stop_count)};
    endproperty
    a_stop_len: assert property (p_stop_len) else $error("frame length wrong for stop count"); // [RQ1]

    property p_cfg_read;
        wr_cfg |=> rd_stop_count_select_o == $past(cfg_stop_count_select_i)
            && rd_activity_mask_o == $past(cfg_activity_mask_i);
    endproperty
    a_cfg_read: assert property (p_cfg_read) else $error("config read-back wrong"); // [RQ3]

    property p_t_reset;
        $rose(rst_n) |-> rd_tx_empty_o && irq_n_o;
    endproperty
    a_t_reset: assert property (p_t_reset) else $error("transmit-empty not set after reset"); // [RQ4]

    property p_inhibit;
        (wr_data && wr_tx_inhibit_i) |=> rts_n_o == !$past(wr_rts_i)
            && q.hold_data == $past(q.hold_data);
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("inhibited write changed data"); // [RQ5]

    property p_tx_src_clr;
        (rd_data && !tx_set) |=> !q.tx_src;
    endproperty
    a_tx_src_clr: assert property (p_tx_src_clr) else $error("data read kept tx source"); // [RQ7]

    property p_avail_irq;
        (rd_rx_avail_o && q.rx_mask) |-> !irq_n_o;
    endproperty
    a_avail_irq: assert property (p_avail_irq) else $error("data-available interrupt missing"); // [RQ11]

    property p_avail_clr;
        (q.count == 4'h1 && rd_data && !push) |=> !rd_rx_avail_o;
    endproperty
    a_avail_clr: assert property (p_avail_clr) else $error("data-available stuck after read"); // [RQ12]

    property p_fe_wrcfg;
        (wr_cfg && !q.in_shdn && !rx_ferr) |=> !rd_activity_or_framing_flag_o;
    endproperty
    a_fe_wrcfg: assert property (p_fe_wrcfg) else $error("config write kept framing flag"); // [RQ19]

    property p_activity;
        (q.in_shdn && q.rx_sync != q.rx_prev) |=> rd_activity_or_framing_flag_o;
    endproperty
    a_activity: assert property (p_activity) else $error("activity not flagged"); // [RQ14]

    property p_irq_idle;
        !(q.tx_src && q.tx_mask) && !(q.act_flag && q.act_mask)
            && !(rd_rx_avail_o && (q.rx_mask || q.ninth_mask)) |-> irq_n_o;
    endproperty
    a_irq_idle: assert property (p_irq_idle) else $error("interrupt without source"); // [RQ20]
endmodule

// [testbench/uitc_line_model.sv]
// Far-end serial line: oversampling tick source and a character sender.
// Assumes the caller invokes its tasks just after a falling clock edge.
`timescale 1ns/10ps
module uitc_line_model (
    // Clock
    input  wire logic clk_i,
    // Line side
    output logic      os_tick_o,
    output logic      rx_o
);
    initial
    begin
        os_tick_o = 1'h0;
        rx_o      = 1'h1;
    end
    // One tick every second cycle, so a bit lasts 32 cycles
    always @(negedge clk_i) os_tick_o <= ~os_tick_o;

    task automatic send_bit(input logic b);
        rx_o = b;
        repeat (32) @(negedge clk_i);
    endtask

    // Start, eight data bits LSB first, optional ninth bit, one stop bit
    task automatic send_char(input logic [7:0] byte_v, input logic ninth_v,
                             input logic ninth_en_v, input logic stop_v);
        send_bit(1'h0);
        for (int i = 0; i < 8; i++) send_bit(byte_v[i]);
        if (ninth_en_v) send_bit(ninth_v);
        send_bit(stop_v);
        send_bit(1'h1);
    endtask

    // Short low pulse on an otherwise idle line
    task automatic pulse_line();
        rx_o = 1'h0;
        repeat (8) @(negedge clk_i);
        rx_o = 1'h1;
        repeat (8) @(negedge clk_i);
    endtask
endmodule

// [testbench/uitc_core_tb.sv]
// Self-checking bench for the UART interrupt and transmit control.
// Assumes uitc_core on one clock and the line model as far end.
`timescale 1ns/10ps
module uitc_core_tb;
    // Clock, reset, counters
    logic       clk_i;
    logic       reset_n_i;
    int         err_count = 0;
    int         tests_run = 0;
    int         cycles    = 0;
    // Inputs
    logic       cs_rise_i;
    logic [1:0] txn_kind_i;
    logic [6:0] cfg;
    logic [3:0] wr;
    logic [7:0] wr_byte;
    logic       os_tick_i;
    logic       rx_i;
    // Outputs
    logic       tx_o, rts_n_o, irq_n_o, tx_empty, rx_avail, rx_ninth, flag;
    logic [6:0] rd_cfg;
    logic [7:0] rx_byte;

    uitc_core u_uitc_core (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .cs_rise_i(cs_rise_i), .txn_kind_i(txn_kind_i),
        .cfg_stop_count_select_i(cfg[0]), .cfg_ninth_bit_enable_i(cfg[1]),
        .cfg_tx_empty_mask_i(cfg[2]), .cfg_rx_avail_mask_i(cfg[3]),
        .cfg_ninth_bit_mask_i(cfg[4]), .cfg_activity_mask_i(cfg[5]), .cfg_shutdown_i(cfg[6]),
        .wr_tx_inhibit_i(wr[0]), .wr_rts_i(wr[1]), .wr_tx_ninth_bit_i(wr[2]),
        .wr_tx_byte_i(wr_byte), .os_tick_i(os_tick_i), .rx_i(rx_i), .tx_o(tx_o),
        .rts_n_o(rts_n_o), .rd_stop_count_select_o(rd_cfg[0]),
        .rd_ninth_bit_enable_o(rd_cfg[1]), .rd_tx_empty_mask_o(rd_cfg[2]),
        .rd_rx_avail_mask_o(rd_cfg[3]), .rd_ninth_bit_mask_o(rd_cfg[4]),
        .rd_activity_mask_o(rd_cfg[5]), .rd_shutdown_o(rd_cfg[6]), .rd_tx_empty_o(tx_empty),
        .rd_rx_avail_o(rx_avail), .rd_rx_ninth_bit_o(rx_ninth),
        .rd_activity_or_framing_flag_o(flag), .rd_rx_byte_o(rx_byte), .irq_n_o(irq_n_o));
    uitc_line_model u_uitc_line_model (.clk_i(clk_i), .os_tick_o(os_tick_i), .rx_o(rx_i));

    initial
    begin
        clk_i = 1'h0;
        forever #4 clk_i = ~clk_i;
    end

    task automatic summarize();
        $display("checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
            err_count++;
        end
    endtask

    // Commit one transaction, then let one more edge land
    task automatic commit(input logic [1:0] kind);
        cs_rise_i  = 1'h1;
        txn_kind_i = kind;
        @(negedge clk_i);
        cs_rise_i  = 1'h0;
        @(negedge clk_i);
    endtask
    task automatic wcfg(input logic [6:0] v);
        cfg = v;
        commit(uitc_pkg::TXN_WR_CFG);
    endtask
    task automatic wdata(input logic [3:0] w, input logic [7:0] b);
        wr      = w;
        wr_byte = b;
        commit(uitc_pkg::TXN_WR_DATA);
    endtask
    task automatic rdata();
        commit(uitc_pkg::TXN_RD_DATA);
    endtask
    task automatic flush();
        for (int n = 0; n < 9 && rx_avail === 1'h1; n++) rdata();
    endtask
    task automatic send(input logic [7:0] b, input logic [2:0] f);
        u_uitc_line_model.send_char(b, f[2], f[1], f[0]);
    endtask

    task automatic t_reset_cfg();
        chk("tx_empty", 8'h01, {7'h00, tx_empty});
        chk("irq_n", 8'h01, {7'h00, irq_n_o});
        chk("cfg_rd", 8'h00, {1'h0, rd_cfg});
        wcfg(7'h01);
        chk("cfg_rd", 8'h01, {1'h0, rd_cfg});
        wcfg(7'h3E);
        chk("cfg_rd", 8'h3E, {1'h0, rd_cfg});
    endtask

    task automatic t_tx_irq();
        int n;
        wcfg(7'h04);
        chk("irq_n", 8'h01, {7'h00, irq_n_o});
        wdata(4'h0, 8'hFF);
        for (n = 0; n < 8 && irq_n_o !== 1'h0; n++) @(negedge clk_i);
        chk("irq_n", 8'h00, {7'h00, irq_n_o});
        rdata();
        chk("irq_n", 8'h01, {7'h00, irq_n_o});
        chk("tx_empty", 8'h01, {7'h00, tx_empty});
        wdata(4'h3, 8'h00);
        chk("rts_n", 8'h00, {7'h00, rts_n_o});
        chk("tx_empty", 8'h01, {7'h00, tx_empty});
        repeat (400) @(negedge clk_i);
        chk("irq_n", 8'h01, {7'h00, irq_n_o});
    endtask

    task automatic t_stop();
        int n;
        for (int st = 0; st < 2; st++)
        begin
            wcfg({6'h00, st[0]});
            wdata(4'h0, 8'hFF);
            for (n = 0; n < 8 && tx_o !== 1'h0; n++) @(negedge clk_i);
            wdata(4'h0, 8'hFF);
            for (n = 2; n < 600 && tx_o !== 1'h1; n++) @(negedge clk_i);
            for (; n < 600 && tx_o !== 1'h0; n++) @(negedge clk_i);
            chk("frame_bits", 8'(10 + st), 8'((n + 16) / 32));
            repeat (400) @(negedge clk_i);
        end
    endtask

    task automatic t_rx();
        wcfg(7'h0B);
        send(8'hA5, 3'h7);
        send(8'h3C, 3'h3);
        chk("rx_avail", 8'h01, {7'h00, rx_avail});
        chk("rx_byte", 8'hA5, rx_byte);
        chk("rx_ninth", 8'h01, {7'h00, rx_ninth});
        rdata();
        chk("rx_byte", 8'h3C, rx_byte);
        chk("rx_ninth", 8'h00, {7'h00, rx_ninth});
        chk("irq_n", 8'h00, {7'h00, irq_n_o});
        rdata();
        chk("rx_avail", 8'h00, {7'h00, rx_avail});
        chk("irq_n", 8'h01, {7'h00, irq_n_o});
        wcfg(7'h12);
        send(8'h12, 3'h7);
        chk("irq_n", 8'h00, {7'h00, irq_n_o});
        rdata();
        wcfg(7'h10);
        send(8'h34, 3'h5);
        chk("rx_ninth", 8'h00, {7'h00, rx_ninth});
        chk("irq_n", 8'h01, {7'h00, irq_n_o});
        rdata();
    endtask

    task automatic t_frame();
        wcfg(7'h20);
        send(8'h55, 3'h0);
        chk("frame_flag", 8'h01, {7'h00, flag});
        chk("irq_n", 8'h00, {7'h00, irq_n_o});
        rdata();
        chk("frame_flag", 8'h01, {7'h00, flag});
        flush();
        send(8'h81, 3'h1);
        chk("frame_flag", 8'h00, {7'h00, flag});
        chk("rx_byte", 8'h81, rx_byte);
        chk("rx_avail", 8'h01, {7'h00, rx_avail});
        send(8'h55, 3'h0);
        wcfg(7'h20);
        chk("frame_flag", 8'h00, {7'h00, flag});
    endtask

    task automatic t_shdn();
        int n;
        flush();
        wcfg(7'h60);
        for (n = 0; n < 100 && rd_cfg[6] !== 1'h1; n++) @(negedge clk_i);
        chk("shutdown", 8'h01, {7'h00, rd_cfg[6]});
        chk("activity", 8'h00, {7'h00, flag});
        u_uitc_line_model.pulse_line();
        chk("activity", 8'h01, {7'h00, flag});
        chk("irq_n", 8'h00, {7'h00, irq_n_o});
        wcfg(7'h20);
        chk("activity", 8'h00, {7'h00, flag});
        chk("irq_n", 8'h01, {7'h00, irq_n_o});
    endtask

    initial
    begin
        reset_n_i  = 1'h0;
        cs_rise_i  = 1'h0;
        txn_kind_i = 2'h0;
        cfg        = 7'h00;
        wr         = 4'h0;
        wr_byte    = 8'h00;
        repeat (10) @(negedge clk_i);
        reset_n_i = 1'h1;
        repeat (3) @(negedge clk_i);
        t_reset_cfg();
        t_tx_irq();
        t_stop();
        t_rx();
        t_frame();
        t_shdn();
        summarize();
    end

    // Hang guard
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            err_count++;
            summarize();
        end
    end
endmodule
